// *** core/sbs_pkg.sv ***
package sbs_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES  = 2;
  localparam int BURST_W = 2;
  localparam int HI_W    = ADDR_W - BURST_W;
  localparam int DEPTH   = 65536;
  localparam int BEAT_W  = 3;

  localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
  localparam logic [BEAT_W-1:0]  BEAT_FIRST = 3'h0;
  localparam logic [BEAT_W-1:0]  BEAT_ONE   = 3'h1;
  localparam logic [BEAT_W-1:0]  BEAT_LAST  = 3'h3;
  localparam logic [BEAT_W-1:0]  BEAT_DONE  = 3'h4;
  localparam logic [DATA_W-1:0]  DATA_ZERO  = 18'h00000;
  localparam logic [ADDR_W-1:0]  ADDR_ZERO  = 16'h0000;
  localparam logic [HI_W-1:0]    HI_ZERO    = 14'h0000;
  localparam logic [LANES-1:0]   LANES_NONE = 2'h0;
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;

  typedef enum logic [2:0] {
    SBS_IDLE  = 3'h1,
    SBS_WRITE = 3'h2,
    SBS_READ  = 3'h4
  } sbs_host_st_type;
endpackage

// *** core/sbs_if.sv ***
interface sbs_if import sbs_pkg::*; ();
  // Strobes and enables, all active low except sleep_request.
  logic                cpu_address_strobe_n;
  logic                cache_ctl_address_strobe_n;
  logic                burst_step_n;
  logic                low_lane_write_n;
  logic                high_lane_write_n;
  logic                select_n;
  logic                out_enable_n;
  logic                sleep_request;
  logic [ADDR_W-1:0]   addr;
  // Shared data bus as separate drives.
  logic [DATA_W-1:0]   host_dq_o;
  logic                host_dq_oe;
  logic [DATA_W-1:0]   mem_dq_o;
  logic                mem_dq_oe;
  logic [DATA_W-1:0]   dq;

  // The memory wins only when it drives; otherwise the controller's value stands.
  assign dq = mem_dq_oe ? mem_dq_o : host_dq_o;

  modport mem (
    input  cpu_address_strobe_n, cache_ctl_address_strobe_n, burst_step_n,
    input  low_lane_write_n, high_lane_write_n, select_n, out_enable_n,
    input  sleep_request, addr, dq,
    output mem_dq_o, mem_dq_oe
  );
  modport host (
    output cpu_address_strobe_n, cache_ctl_address_strobe_n, burst_step_n,
    output low_lane_write_n, high_lane_write_n, select_n, out_enable_n,
    output sleep_request, addr, host_dq_o, host_dq_oe,
    input  dq
  );
endinterface

// *** core/sbs_burst_ctr.sv ***
module sbs_burst_ctr
  import sbs_pkg::*;
(
  // Clock and reset.
  input  wire logic               mclk,
  input  wire logic               reset,
  // Control.
  input  wire logic               load,
  input  wire logic [BURST_W-1:0] load_val,
  input  wire logic               step,
  // Count.
  output logic      [BURST_W-1:0] cnt,
  output logic      [BURST_W-1:0] cnt_next
);
  typedef struct packed {
    logic [BURST_W-1:0] cnt;
  } sbs_ctr_type;

  sbs_ctr_type q;
  sbs_ctr_type d;

  assign cnt      = q.cnt;
  assign cnt_next = q.cnt + BURST_ONE;

  always_comb begin
    d = q;
    if (load) begin
      d.cnt = load_val;
    end else if (step) begin
      d.cnt = cnt_next;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// *** core/sbs_mem.sv ***
// How it works
// [RULE1] Inputs sampled on rising edge; output enable async.
// [RULE2] CPU strobe with select loads address, reads.
// [RULE3] Advance ignored on CPU strobe edge.
// [RULE4] Read burst steps when writes high, advance low.
// [RULE5] Write enables ignored on CPU strobe edge.
// [RULE6] Any write enable low floats data outputs.
// [RULE7] Write enable low registers the data bus.
// [RULE8] Write burst steps when write and advance low.
// [RULE9] Low enable writes low half, high enable high.
// [RULE10] Controller strobe starts write or read burst.
// [RULE11] Controller start needs CPU strobe held high.
// [RULE12] Controller start samples write enables same edge.
// [RULE13] Burst counts up from external low bits.
// [RULE14] Two-bit counter wraps after four addresses.
// [RULE15] Strobes high: advance steps, else wait state.
// [RULE16] Strobe without select means not selected.
// [RULE17] Drive when output enable low and selected.
// [RULE18] Controller raises output enable before write after read.
// [RULE19] Writes self-timed, synchronous to the clock.
// [RULE20] Sleep request powers down, clock or not.
// [RULE21] Array holds 65536 words of 18 bits.
// [RULE22] Read data valid in period after edge.
module sbs_mem
  import sbs_pkg::*;
(
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic reset,
  // Memory pins.
  sbs_if.mem        pins,
  // Status.
  output logic      busy,
  output logic      powered_down
);
  typedef struct packed {
    logic                active;
    logic                wr_seen;
    logic [HI_W-1:0]     base_hi;
    logic                pend;
    logic [ADDR_W-1:0]   pend_addr;
    logic [LANES-1:0]    pend_lanes;
    logic [DATA_W-1:0]   din;
    logic                asleep;
  } sbs_mem_type;

  sbs_mem_type q;
  sbs_mem_type d;

  logic [DATA_W-1:0]  store [DEPTH];
  logic               ctr_load;
  logic               ctr_step;
  logic [BURST_W-1:0] ctr_cnt;
  logic [BURST_W-1:0] ctr_next;
  logic               start_cpu;
  logic               start_ctl;
  logic               any_write;
  logic [LANES-1:0]   lanes;
  logic [ADDR_W-1:0]  rd_addr;
  logic [DATA_W-1:0]  rd_word;

  sbs_burst_ctr u_ctr (
    .mclk     (mclk),
    .reset    (reset),
    .load     (ctr_load),
    .load_val (pins.addr[BURST_W-1:0]),
    .step     (ctr_step),
    .cnt      (ctr_cnt),
    .cnt_next (ctr_next)
  );

  // The CPU strobe takes priority over the controller strobe.
  assign start_cpu = !pins.cpu_address_strobe_n;
  assign start_ctl = pins.cpu_address_strobe_n && !pins.cache_ctl_address_strobe_n; // [RULE11]
  assign lanes     = {!pins.high_lane_write_n, !pins.low_lane_write_n};
  assign any_write = |lanes;

  always_comb begin
    d        = q;
    ctr_load = 1'b0;
    ctr_step = 1'b0;
    d.pend   = 1'b0;
    d.asleep = pins.sleep_request;
    // While asleep every pin except sleep request is ignored and state is held.
    if (pins.sleep_request) begin // [RULE20]
      d.pend = q.pend;
    end else if (start_cpu) begin // [RULE1]
      if (!pins.select_n) begin
        // Advance and write enables are not looked at on this edge.
        d.active  = 1'b1; // [RULE2] [RULE3] [RULE5]
        d.wr_seen = 1'b0;
        d.base_hi = pins.addr[ADDR_W-1:BURST_W];
        ctr_load  = 1'b1; // [RULE13]
      end else begin
        d.active  = 1'b0; // [RULE16]
        d.wr_seen = 1'b0;
      end
    end else if (start_ctl) begin
      if (!pins.select_n) begin
        d.active  = 1'b1; // [RULE10]
        d.wr_seen = any_write; // [RULE12]
        d.base_hi = pins.addr[ADDR_W-1:BURST_W];
        ctr_load  = 1'b1; // [RULE13]
        if (any_write) begin
          d.pend       = 1'b1; // [RULE7]
          d.pend_addr  = pins.addr;
          d.pend_lanes = lanes;
          d.din        = pins.dq;
        end
      end else begin
        d.active  = 1'b0; // [RULE16]
        d.wr_seen = 1'b0;
      end
    end else if (q.active) begin
      // Both strobes high: select is not examined here.
      ctr_step  = !pins.burst_step_n; // [RULE4] [RULE8] [RULE15]
      d.wr_seen = any_write;
      if (any_write) begin
        d.pend       = 1'b1; // [RULE7]
        d.pend_addr  = {q.base_hi, pins.burst_step_n ? ctr_cnt : ctr_next}; // [RULE14]
        d.pend_lanes = lanes;
        d.din        = pins.dq;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Self-timed write from the input register one cycle after capture.
  always_ff @(posedge mclk) begin
    if (q.pend) begin // [RULE19]
      if (q.pend_lanes[LANE_LO]) begin
        store[q.pend_addr][LANE_W-1:0] <= q.din[LANE_W-1:0]; // [RULE9]
      end
      if (q.pend_lanes[LANE_HI]) begin
        store[q.pend_addr][DATA_W-1:LANE_W] <= q.din[DATA_W-1:LANE_W]; // [RULE9]
      end
    end
  end

  // Flow-through read with bypass of a write still in the input register.
  assign rd_addr = {q.base_hi, ctr_cnt}; // [RULE21]

  always_comb begin
    rd_word = store[rd_addr]; // [RULE22]
    if (q.pend && (q.pend_addr == rd_addr)) begin
      if (q.pend_lanes[LANE_LO]) begin
        rd_word[LANE_W-1:0] = q.din[LANE_W-1:0];
      end
      if (q.pend_lanes[LANE_HI]) begin
        rd_word[DATA_W-1:LANE_W] = q.din[DATA_W-1:LANE_W];
      end
    end
  end

  assign pins.mem_dq_o  = rd_word;
  // Output enable acts without the clock; a write or a deselect wins over it.
  assign pins.mem_dq_oe = q.active && !q.wr_seen && !pins.out_enable_n // [RULE6] [RULE17]
                          && !pins.sleep_request; // [RULE20]

  assign busy         = q.active;
  assign powered_down = q.asleep;
endmodule

// *** core/sbs_ctl.sv ***
module sbs_ctl
  import sbs_pkg::*;
(
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              reset,
  // Memory pins.
  sbs_if.host                    pins,
  // Burst command.
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_write,
  input  wire logic              cmd_use_cpu,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [LANES-1:0]  cmd_lanes,
  // Write data, one word per take pulse.
  input  wire logic [DATA_W-1:0] wr_data,
  output logic                   wr_take,
  // Read data.
  output logic [DATA_W-1:0]      rd_data,
  output logic                   rd_valid,
  // Power down.
  input  wire logic              sleep_in
);
  typedef struct packed {
    sbs_host_st_type     st;
    logic [BEAT_W-1:0]   beat;
    logic                cpu_n;
    logic                ctl_n;
    logic                step_n;
    logic                low_n;
    logic                high_n;
    logic                sel_n;
    logic                oe_n;
    logic                sleep;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_o;
    logic                dq_oe;
    logic [LANES-1:0]    lanes;
    logic [DATA_W-1:0]   rd_data;
    logic                rd_valid;
  } sbs_ctl_type;

  localparam sbs_ctl_type CTL_RESET = '{
    st: SBS_IDLE, beat: BEAT_FIRST, cpu_n: 1'b1, ctl_n: 1'b1, step_n: 1'b1,
    low_n: 1'b1, high_n: 1'b1, sel_n: 1'b1, oe_n: 1'b1, sleep: 1'b0,
    addr: ADDR_ZERO, dq_o: DATA_ZERO, dq_oe: 1'b0, lanes: LANES_NONE,
    rd_data: DATA_ZERO, rd_valid: 1'b0};

  sbs_ctl_type q;
  sbs_ctl_type d;

  assign cmd_ready = (q.st == SBS_IDLE) && !q.sleep;

  always_comb begin
    d          = q;
    wr_take    = 1'b0;
    d.rd_valid = 1'b0;
    d.sleep    = sleep_in;
    unique case (q.st)
      SBS_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          d.beat  = BEAT_FIRST;
          d.sel_n = 1'b0; // [RULE16]
          d.addr  = cmd_addr;
          d.lanes = cmd_lanes;
          if (cmd_write) begin
            // Outputs of the memory stay released before the bus is driven.
            d.st     = SBS_WRITE;
            d.oe_n   = 1'b1; // [RULE18]
            d.ctl_n  = 1'b0;
            d.cpu_n  = 1'b1; // [RULE11]
            d.low_n  = !cmd_lanes[LANE_LO]; // [RULE9]
            d.high_n = !cmd_lanes[LANE_HI];
            d.dq_o   = wr_data;
            d.dq_oe  = 1'b1;
            wr_take  = 1'b1;
          end else begin
            d.st    = SBS_READ;
            d.oe_n  = 1'b0;
            d.cpu_n = !cmd_use_cpu;
            d.ctl_n = cmd_use_cpu;
          end
        end
      end
      SBS_WRITE: begin
        d.cpu_n = 1'b1;
        d.ctl_n = 1'b1;
        if (q.beat == BEAT_LAST) begin
          d = CTL_RESET;
          d.sleep = sleep_in;
        end else begin
          d.beat   = q.beat + BEAT_ONE;
          d.step_n = 1'b0;
          d.dq_o   = wr_data;
          wr_take  = 1'b1;
        end
      end
      SBS_READ: begin
        d.cpu_n = 1'b1;
        d.ctl_n = 1'b1;
        if (q.beat != BEAT_FIRST) begin
          d.rd_data  = pins.dq;
          d.rd_valid = 1'b1;
        end
        if (q.beat == BEAT_DONE) begin
          d          = CTL_RESET;
          d.sleep    = sleep_in;
          d.rd_data  = pins.dq;
          d.rd_valid = 1'b1;
        end else begin
          d.beat   = q.beat + BEAT_ONE;
          d.step_n = (q.beat == BEAT_LAST);
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= CTL_RESET;
    end else begin
      q <= d;
    end
  end

  assign pins.cpu_address_strobe_n       = q.cpu_n;
  assign pins.cache_ctl_address_strobe_n = q.ctl_n;
  assign pins.burst_step_n               = q.step_n;
  assign pins.low_lane_write_n           = q.low_n;
  assign pins.high_lane_write_n          = q.high_n;
  assign pins.select_n                   = q.sel_n;
  assign pins.out_enable_n               = q.oe_n;
  assign pins.sleep_request              = q.sleep;
  assign pins.addr                       = q.addr;
  assign pins.host_dq_o                  = q.dq_o;
  assign pins.host_dq_oe                 = q.dq_oe;
  assign rd_data                         = q.rd_data;
  assign rd_valid                        = q.rd_valid;
endmodule

// *** tb/sbs_assertions.sv ***
module sbs_assertions (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Interface signals.
  input wire logic cpu_address_strobe_n,
  input wire logic cache_ctl_address_strobe_n,
  input wire logic low_lane_write_n,
  input wire logic high_lane_write_n,
  input wire logic select_n,
  input wire logic out_enable_n,
  input wire logic sleep_request,
  input wire logic host_dq_oe,
  input wire logic mem_dq_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  wr_float_a: assert property
    (!sleep_request && !(low_lane_write_n && high_lane_write_n) |=> !mem_dq_oe)
    else $error("memory drove after a write enable edge");
  ctl_start_a: assert property (!cache_ctl_address_strobe_n |-> cpu_address_strobe_n)
    else $error("controller strobe with cpu strobe low");
  sel_held_a: assert property
    (!(cpu_address_strobe_n && cache_ctl_address_strobe_n) |-> !select_n)
    else $error("strobe without select");
  oe_off_a: assert property (out_enable_n |-> !mem_dq_oe)
    else $error("memory drove with output enable high");
  sleep_off_a: assert property (sleep_request |-> !mem_dq_oe)
    else $error("memory drove while asleep");
  no_fight_a: assert property (!(host_dq_oe && mem_dq_oe))
    else $error("both ends drove the data bus");
  cpu_read_a: assert property (!cpu_address_strobe_n && !select_n && !sleep_request
    && low_lane_write_n && high_lane_write_n ##1 (!out_enable_n && !sleep_request) |-> mem_dq_oe)
    else $error("no read data after cpu strobe");
  ctl_read_a: assert property (!cache_ctl_address_strobe_n && !select_n &&
    cpu_address_strobe_n && low_lane_write_n && high_lane_write_n && !sleep_request
    ##1 (!out_enable_n && !sleep_request) |-> mem_dq_oe)
    else $error("no read data after controller strobe");

  cover property (!cpu_address_strobe_n && !select_n);
  cover property (!cache_ctl_address_strobe_n && !low_lane_write_n);
  cover property (sleep_request);
endmodule

// *** tb/tb.sv ***
module tb
  import sbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              mclk;
  logic              reset;
  logic              cmd_valid;
  logic              cmd_ready;
  logic              cmd_write;
  logic              cmd_use_cpu;
  logic [ADDR_W-1:0] cmd_addr;
  logic [LANES-1:0]  cmd_lanes;
  logic [DATA_W-1:0] wr_data;
  logic              wr_take;
  logic [DATA_W-1:0] rd_data;
  logic              rd_valid;
  logic              sleep_in;
  logic              busy;
  logic              powered_down;
  int                errors;
  int                cmp_count;
  logic [31:0]       seed;
  logic [DATA_W-1:0] mdl [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] w [4];

  sbs_if sbs_if_inst ();
  sbs_mem sbs_mem_inst (.mclk(mclk), .reset(reset), .pins(sbs_if_inst.mem), .busy(busy),
    .powered_down(powered_down));
  sbs_ctl sbs_ctl_inst (.mclk(mclk), .reset(reset), .pins(sbs_if_inst.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_use_cpu(cmd_use_cpu), .cmd_addr(cmd_addr), .cmd_lanes(cmd_lanes),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .sleep_in(sleep_in));
  sbs_assertions sbs_assertions_inst (.mclk(mclk), .reset(reset),
    .cpu_address_strobe_n(sbs_if_inst.cpu_address_strobe_n),
    .cache_ctl_address_strobe_n(sbs_if_inst.cache_ctl_address_strobe_n),
    .low_lane_write_n(sbs_if_inst.low_lane_write_n),
    .high_lane_write_n(sbs_if_inst.high_lane_write_n),
    .select_n(sbs_if_inst.select_n), .out_enable_n(sbs_if_inst.out_enable_n),
    .sleep_request(sbs_if_inst.sleep_request), .host_dq_oe(sbs_if_inst.host_dq_oe),
    .mem_dq_oe(sbs_if_inst.mem_dq_oe));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Burst beats keep the high bits and count the low two bits modulo four.
  function automatic logic [ADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] a, input int k);
    return {a[ADDR_W-1:BURST_W], a[BURST_W-1:0] + BURST_W'(k)};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln);
    logic [DATA_W-1:0] m;
    logic [ADDR_W-1:0] x;
    logic              tk;
    int                i;
    int                takes;
    i = 0;
    takes = 0;
    m = {{LANE_W{ln[LANE_HI]}}, {LANE_W{ln[LANE_LO]}}};
    for (int k = 0; k < 4; k++) begin
      w[k] = DATA_W'(rnd());
      x = beat_addr(a, k);
      mdl[x] = (w[k] & m) | ((mdl.exists(x) ? mdl[x] : DATA_ZERO) & ~m);
    end
    @(negedge mclk);
    while (cmd_ready !== 1'b1) @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_addr = a;
    cmd_lanes = ln;
    wr_data = w[0];
    repeat (7) begin
      #1;
      tk = wr_take;
      @(negedge mclk);
      cmd_valid = 1'b0;
      if (tk === 1'b1) takes++;
      if (tk === 1'b1 && i < 3) i++;
      wr_data = w[i];
    end
    chk(takes, 4);
  endtask

  task automatic do_read(input logic [ADDR_W-1:0] a, input logic cpu);
    int k;
    k = 0;
    @(negedge mclk);
    while (cmd_ready !== 1'b1) @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_write = 1'b0;
    cmd_use_cpu = cpu;
    cmd_addr = a;
    repeat (9) begin
      @(negedge mclk);
      cmd_valid = 1'b0;
      if (rd_valid === 1'b1) begin
        chk(rd_data, mdl[beat_addr(a, k)]);
        k++;
      end
    end
    chk(k, 4);
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // About 26 cycles per pass; the limit leaves ample margin.
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    close_out();
  end

  initial begin
    logic [31:0]       r;
    logic [ADDR_W-1:0] a;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_use_cpu = 1'b0;
    cmd_addr = ADDR_ZERO;
    cmd_lanes = LANES_NONE;
    wr_data = DATA_ZERO;
    sleep_in = 1'b0;
    seed = 32'h22;
    errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    chk(busy, 1'b0);
    for (int t = 0; t < 24; t++) begin
      r = rnd();
      a = (t < 4) ? {r[HI_W-1:0], BURST_W'(t)} : r[ADDR_W-1:0];
      if (t == 7) a = 16'hFFFF;
      do_write(a, 2'h3);
      do_write(a, (r[17:16] == 2'h0) ? 2'h1 : r[17:16]);
      do_read(a, r[20]);
    end
    chk(busy, 1'b1);
    @(negedge mclk);
    sleep_in = 1'b1;
    repeat (3) @(negedge mclk);
    chk(powered_down, 1'b1);
    chk(cmd_ready, 1'b0);
    sleep_in = 1'b0;
    repeat (3) @(negedge mclk);
    chk(powered_down, 1'b0);
    do_read(a, 1'b1);
    close_out();
  end
endmodule
